//--- rtl/cpi_core_protection.sv
// Design decisions made here: register access over Wishbone and the register offsets.
`default_nettype none
`include "cpi_regs.svh"
module cpi_core_protection
    import cpi_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     reset,
    input  wire logic                     clockEnable,
    input  wire logic                     wbCyc,
    input  wire logic                     wbStb,
    input  wire logic                     wbWe,
    input  wire logic [`CPI_ADDR_BITS-1:0] wbAdr,
    input  wire logic [3:0]               wbSel,
    input  wire logic [31:0]              wbDatIn,
    output logic [31:0]                   wbDatOut,
    output logic                          wbAck,
    input  wire logic                     ifValid,
    input  wire logic [31:0]              ifAddr,
    input  wire logic                     dataValid,
    input  wire logic [31:0]              dataAddr,
    input  wire logic                     dataWrite,
    output logic                          ifFault,
    output logic                          dataFault,
    output logic                          memFaultExc,
    output logic                          tickExc,
    input  wire logic [`CPI_NUM_IRQ-1:0]  irqLine,
    output logic                          excValid,
    output logic [5:0]                    excNum,
    output logic [31:0]                   excVector,
    input  wire logic                     excAck,
    output logic                          nmiOut,
    output logic [2:0]                    sysClkSel,
    output logic                          irq
);
    cpi_state_t                st_reg;
    cpi_state_t                st_next;
    logic                      iOk;
    logic                      dOk;
    logic [`CPI_TICK_BITS-1:0] tickValue;
    logic                      tickWrap;
    logic                      busReq;
    logic [`CPI_NUM_IRQ-1:0]   nmiMask;

    assign busReq      = wbCyc && wbStb && !st_reg.ack;
    assign wbAck       = st_reg.ack;
    assign wbDatOut    = st_reg.rdata;
    assign ifFault     = st_reg.iFault;
    assign dataFault   = st_reg.dFault;
    assign memFaultExc = st_reg.iFault || st_reg.dFault;
    assign tickExc     = st_reg.tickExc;
    assign excValid    = st_reg.excValid;
    assign excNum      = st_reg.excNum;
    assign excVector   = st_reg.excVector;
    assign nmiOut      = st_reg.nmi;
    assign sysClkSel   = st_reg.clkSel;
    assign irq         = |(st_reg.intStat & st_reg.intMask);
    assign nmiMask     = (`CPI_NUM_IRQ'(1) << st_reg.nmiSrc)
                         & {`CPI_NUM_IRQ{st_reg.nmiEn}};

    // ---------------------------------------------
    // Checkers: fetch and data paths side by side
    // ---------------------------------------------
    cpi_region_protection_unit fetchCheck ( // R11
        .regions (st_reg.region),
        .addr    (st_reg.iAddr),
        .write   (1'b0),
        .allowed (iOk)
    );

    cpi_region_protection_unit dataCheck (
        .regions (st_reg.region),
        .addr    (st_reg.dAddr),
        .write   (st_reg.dWr),
        .allowed (dOk)
    );

    cpi_periodic_core_timer tickTimer (
        .clock       (clock),
        .reset       (reset),
        .clockEnable (clockEnable),
        .enable      (st_reg.tickEn),
        .useDivided  (st_reg.tickDiv),
        .restart     (st_reg.reloadWr),
        .reload      (st_reg.reload),
        .value       (tickValue),
        .wrap        (tickWrap)
    );

    // ---------------------------------------------
    // Next state
    // ---------------------------------------------
    always_comb begin
        logic [2:0]  p;
        logic [2:0]  bestPri;
        logic [5:0]  bestNum;
        logic        found;
        logic [31:0] rd;
        logic [2:0]  k;
        logic [2:0]  n;
        logic [2:0]  ev;
        p = 3'h0;
        bestPri = 3'h7;
        bestNum = 6'h00;
        found = 1'b0;
        rd = 32'h00000000;
        k = wbAdr[4:2];
        n = wbAdr[5:3];
        ev = 3'h0;
        st_next = st_reg;
        st_next.ack = 1'b0;
        st_next.reloadWr = 1'b0;

        // Request, check, report: one access per stage per cycle
        st_next.iAddr = ifAddr; // R10
        st_next.iVld = ifValid;
        st_next.dAddr = dataAddr;
        st_next.dVld = dataValid;
        st_next.dWr = dataWrite;
        st_next.iFault = st_reg.iVld && st_reg.protEn && !iOk; // R3
        st_next.dFault = st_reg.dVld && st_reg.protEn && !dOk; // R3
        if (st_next.iFault) begin
            st_next.faultAddr = st_reg.iAddr;
        end else if (st_next.dFault) begin
            st_next.faultAddr = st_reg.dAddr;
        end
        st_next.tickExc = tickWrap; // R4
        ev[`CPI_ST_FAULT] = st_next.iFault || st_next.dFault;
        ev[`CPI_ST_TICK] = tickWrap;

        // Ack clears pending; a line still high sets it again
        if (excAck && st_reg.excValid) begin
            st_next.pend[st_reg.excNum] = 1'b0;
        end
        st_next.pend = st_next.pend | (irqLine & ~nmiMask); // R12

        // ---------------------------------------------
        // Register bus
        // ---------------------------------------------
        if (busReq) begin
            st_next.ack = 1'b1;
            case ({wbAdr[7:2], 2'b00})
                `CPI_OFS_CTRL: begin
                    rd[`CPI_CTRL_PROT_EN] = st_reg.protEn;
                    rd[`CPI_CTRL_TICK_EN] = st_reg.tickEn;
                    rd[`CPI_CTRL_TICK_DIV] = st_reg.tickDiv;
                    rd[`CPI_CTRL_CLK_LSB +: 3] = st_reg.clkSel;
                    rd[`CPI_CTRL_MASK_LSB +: 3] = st_reg.maskLvl;
                end
                `CPI_OFS_RELOAD:    rd = 32'(st_reg.reload);
                `CPI_OFS_TICK_VAL:  rd = 32'(tickValue);
                `CPI_OFS_VEC_BASE:  rd = st_reg.vecBase;
                `CPI_OFS_NMI_SEL: begin
                    rd[5:0] = st_reg.nmiSrc;
                    rd[`CPI_NMI_EN_BIT] = st_reg.nmiEn;
                end
                `CPI_OFS_IRQ_EN0:   rd = st_reg.irqEn[31:0];
                `CPI_OFS_IRQ_EN1:   rd = 32'(st_reg.irqEn[55:32]);
                `CPI_OFS_PEND0:     rd = st_reg.pend[31:0];
                `CPI_OFS_PEND1:     rd = 32'(st_reg.pend[55:32]);
                `CPI_OFS_ACTIVE: begin
                    rd[5:0] = st_reg.excNum;
                    rd[10:8] = st_reg.excPrio;
                    rd[16] = st_reg.excValid;
                end
                `CPI_OFS_INT_STAT:  rd = 32'(st_reg.intStat);
                `CPI_OFS_INT_MASK:  rd = 32'(st_reg.intMask);
                `CPI_OFS_FAULT_ADR: rd = st_reg.faultAddr;
                default: begin
                    if (wbAdr[7:5] == 3'b010 && k < `CPI_PRIO_WORDS) begin
                        for (int j = 0; j < 8; j++) begin
                            rd[4*j +: 3] = st_reg.prio[3*(8*k+j) +: 3];
                        end
                    end else if (wbAdr[7:6] == 2'b10) begin
                        rd = wbAdr[2] ? 32'({st_reg.region[n].subOff,
                                3'h0, st_reg.region[n].sizeLog,
                                5'h00, st_reg.region[n].access,
                                st_reg.region[n].enable})
                             : st_reg.region[n].base;
                    end
                end
            endcase
            if (!wbWe) begin
                st_next.rdata = rd;
            end else if (wbSel != 4'hf) begin
                ev[`CPI_ST_WIDTH] = 1'b1; // R8
            end else begin
                case ({wbAdr[7:2], 2'b00})
                    `CPI_OFS_CTRL: begin
                        st_next.protEn = wbDatIn[`CPI_CTRL_PROT_EN];
                        st_next.tickEn = wbDatIn[`CPI_CTRL_TICK_EN];
                        st_next.tickDiv = wbDatIn[`CPI_CTRL_TICK_DIV];
                        st_next.maskLvl = wbDatIn[`CPI_CTRL_MASK_LSB +: 3];
                        // Unsupported rate codes keep the old clock
                        if (wbDatIn[`CPI_CTRL_CLK_LSB +: 3]
                                <= `CPI_CLK_SEL_MAX) begin
                            st_next.clkSel =
                                wbDatIn[`CPI_CTRL_CLK_LSB +: 3]; // R9
                        end
                    end
                    `CPI_OFS_RELOAD: begin
                        st_next.reload = wbDatIn[`CPI_TICK_BITS-1:0];
                        st_next.reloadWr = 1'b1;
                    end
                    `CPI_OFS_VEC_BASE:
                        st_next.vecBase = wbDatIn & `CPI_VEC_ALIGN; // R6
                    `CPI_OFS_NMI_SEL: begin
                        st_next.nmiSrc = wbDatIn[5:0]; // R7
                        st_next.nmiEn = wbDatIn[`CPI_NMI_EN_BIT];
                    end
                    `CPI_OFS_IRQ_EN0: st_next.irqEn[31:0] = wbDatIn;
                    `CPI_OFS_IRQ_EN1:
                        st_next.irqEn[55:32] = wbDatIn[23:0];
                    `CPI_OFS_PEND0:
                        st_next.pend[31:0] =
                            st_next.pend[31:0] | wbDatIn; // R12
                    `CPI_OFS_PEND1:
                        st_next.pend[55:32] =
                            st_next.pend[55:32] | wbDatIn[23:0];
                    `CPI_OFS_INT_STAT:
                        st_next.intStat = st_reg.intStat & ~wbDatIn[2:0];
                    `CPI_OFS_INT_MASK: st_next.intMask = wbDatIn[2:0];
                    default: begin
                        if (wbAdr[7:5] == 3'b010
                                && k < `CPI_PRIO_WORDS) begin
                            for (int j = 0; j < 8; j++) begin
                                st_next.prio[3*(8*k+j) +: 3] =
                                    wbDatIn[4*j +: 3];
                            end
                        end else if (wbAdr[7:6] == 2'b10) begin
                            if (wbAdr[2]) begin
                                st_next.region[n].enable =
                                    wbDatIn[`CPI_RA_EN];
                                st_next.region[n].access =
                                    wbDatIn[`CPI_RA_ACC_LSB +: 2];
                                st_next.region[n].sizeLog =
                                    wbDatIn[`CPI_RA_SIZE_LSB +: 5];
                                st_next.region[n].subOff =
                                    wbDatIn[`CPI_RA_SUB_LSB +: 8]; // R13
                            end else begin
                                st_next.region[n].base = wbDatIn;
                            end
                        end
                    end
                endcase
            end
        end
        // Events win over a same-cycle clear
        st_next.intStat = st_next.intStat | ev;

        // ---------------------------------------------
        // Arbitration, lowest value most urgent
        // ---------------------------------------------
        for (int i = 0; i < `CPI_NUM_IRQ; i++) begin
            p = st_reg.prio[3*i +: 3];
            if (st_reg.pend[i] && st_reg.irqEn[i]
                    && (st_reg.maskLvl == 3'h0
                        || p < st_reg.maskLvl) // R5
                    && (!found || p < bestPri)) begin
                found = 1'b1;
                bestPri = p;
                bestNum = 6'(i);
            end
        end
        // The taken entry is not shown again before it clears
        st_next.excValid = found && !(excAck && st_reg.excValid);
        st_next.excNum = bestNum;
        st_next.excPrio = bestPri;
        st_next.excVector = st_reg.vecBase + {24'h000000, bestNum, 2'b00}
                            + `CPI_VEC_FIRST_OFS; // R6
        st_next.nmi = st_reg.nmiEn && st_reg.nmiSrc < 6'(`CPI_NUM_IRQ)
                      && irqLine[st_reg.nmiSrc]; // R7
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg <= '0;
        end else if (clockEnable) begin
            st_reg <= st_next;
        end
    end

    // ---------------------------------------------
    // Assertions
    // ---------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    sequence wbReq;
        clockEnable && wbCyc && wbStb && !wbAck;
    endsequence

    sequence fetchIssued;
        clockEnable && ifValid && st_reg.protEn;
    endsequence

    sequence dataIssued;
        clockEnable && dataValid && st_reg.protEn;
    endsequence

    wb_ack_a: assert property (wbReq |=> wbAck)
        else $error("bus request not acknowledged");

    ack_pulse_a: assert property (clockEnable && wbAck |=> !wbAck)
        else $error("bus ack held longer than a cycle");

    width_refuse_a: assert property ( // R8
        wbReq ##0 (wbWe && wbSel != 4'hf)
        |=> st_reg.intStat[`CPI_ST_WIDTH])
        else $error("partial write not flagged");

    fetch_fault_a: assert property ( // R3
        fetchIssued ##1 (clockEnable && st_reg.protEn && !iOk)
        |=> ifFault && memFaultExc)
        else $error("fetch fault missing after two stages");

    data_fault_a: assert property ( // R3
        dataIssued ##1 (clockEnable && st_reg.protEn && !dOk)
        |=> dataFault && memFaultExc)
        else $error("data fault missing after two stages");

    mask_hold_a: assert property ( // R5
        excValid |-> ($past(st_reg.maskLvl) == 3'h0
                      || st_reg.excPrio < $past(st_reg.maskLvl)))
        else $error("masked interrupt presented");

    nmi_route_a: assert property ( // R7
        clockEnable && st_reg.nmiEn && st_reg.nmiSrc < 6'd56
        && irqLine[st_reg.nmiSrc] |=> nmiOut)
        else $error("selected source did not raise nmi");

    ack_clear_a: assert property ( // R12
        clockEnable && excAck && excValid && !irqLine[excNum]
        && !(wbCyc && wbStb) |=> !st_reg.pend[$past(excNum)])
        else $error("acknowledged interrupt still pending");

    vector_addr_a: assert property ( // R6
        clockEnable && excValid |-> excVector == $past(st_reg.vecBase)
        + {24'h000000, excNum, 2'b00} + 32'h00000040)
        else $error("vector address wrong");

    clk_sel_a: assert property ( // R9
        wbReq ##0 (wbWe && wbSel == 4'hf && wbAdr == 8'h00
        && wbDatIn[6:4] > 3'h4) |=> $stable(sysClkSel))
        else $error("unsupported clock code accepted");

    tick_status_a: assert property ( // R4
        clockEnable && tickWrap
        |=> tickExc && st_reg.intStat[`CPI_ST_TICK])
        else $error("tick wrap not reported");
endmodule
`default_nettype wire

//--- rtl/cpi_periodic_core_timer.sv
`default_nettype none
`include "cpi_regs.svh"
module cpi_periodic_core_timer
    import cpi_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      reset,
    input  wire logic                      clockEnable,
    input  wire logic                      enable,
    input  wire logic                      useDivided,
    input  wire logic                      restart,
    input  wire logic [`CPI_TICK_BITS-1:0] reload,
    output logic [`CPI_TICK_BITS-1:0]      value,
    output logic                           wrap
);
    cpi_tick_state_t st_reg;
    cpi_tick_state_t st_next;
    logic            step;

    assign step  = enable && (!useDivided || st_reg.div == `CPI_TICK_DIV);
    assign value = st_reg.value;
    assign wrap  = st_reg.wrap;

    always_comb begin
        st_next = st_reg;
        st_next.wrap = 1'b0;
        if (enable) begin
            st_next.div = st_reg.div + 3'h1;
        end
        if (restart) begin
            st_next.value = reload;
            st_next.div = 3'h0;
        end else if (step) begin
            if (st_reg.value == '0) begin
                st_next.value = reload;
                st_next.wrap = (reload != '0); // R4
            end else begin
                st_next.value = st_reg.value - 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg <= '0;
        end else if (clockEnable) begin
            st_reg <= st_next;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    tick_reload_a: assert property ( // R4
        clockEnable && step && !restart && st_reg.value == '0
        && reload != '0 |=> wrap && value == $past(reload))
        else $error("tick did not reload and signal");
endmodule
`default_nettype wire

//--- rtl/cpi_pkg.sv
`default_nettype none
`include "cpi_regs.svh"
package cpi_pkg;

    typedef enum logic [1:0] {
        CPI_NO_ACCESS,
        CPI_READ_ONLY,
        CPI_READ_WRITE
    } cpi_access_t;

    typedef struct packed {
        logic [7:0]  subOff;
        logic [4:0]  sizeLog;
        logic [1:0]  access;
        logic        enable;
        logic [31:0] base;
    } cpi_region_t;

    typedef struct packed {
        logic [`CPI_TICK_BITS-1:0] value;
        logic [2:0]                div;
        logic                      wrap;
    } cpi_tick_state_t;

    typedef struct packed {
        logic                         ack;
        logic [31:0]                  rdata;
        logic                         protEn;
        logic                         tickEn;
        logic                         tickDiv;
        logic [2:0]                   clkSel;
        logic [2:0]                   maskLvl;
        logic [`CPI_TICK_BITS-1:0]    reload;
        logic                         reloadWr;
        logic [31:0]                  vecBase;
        logic                         nmiEn;
        logic [5:0]                   nmiSrc;
        logic [`CPI_NUM_IRQ-1:0]      irqEn;
        logic [`CPI_NUM_IRQ-1:0]      pend;
        logic [3*`CPI_NUM_IRQ-1:0]    prio;
        logic [2:0]                   intStat;
        logic [2:0]                   intMask;
        cpi_region_t [7:0]            region;
        logic [31:0]                  faultAddr;
        logic [31:0]                  iAddr;
        logic                         iVld;
        logic [31:0]                  dAddr;
        logic                         dVld;
        logic                         dWr;
        logic                         iFault;
        logic                         dFault;
        logic                         tickExc;
        logic                         excValid;
        logic [5:0]                   excNum;
        logic [2:0]                   excPrio;
        logic [31:0]                  excVector;
        logic                         nmi;
    } cpi_state_t;

endpackage
`default_nettype wire

//--- rtl/cpi_region_protection_unit.sv
`default_nettype none
`include "cpi_regs.svh"
module cpi_region_protection_unit
    import cpi_pkg::*;
(
    input  wire cpi_region_t [7:0] regions,
    input  wire logic [31:0]       addr,
    input  wire logic              write,
    output logic                   allowed
);
    logic [7:0] hit;

    genvar g;
    generate
        for (g = 0; g < `CPI_NUM_REGION; g++) begin : gRegion
            logic [4:0]  sz;
            logic [31:0] sub;
            // Below the minimum size the sub-region split breaks down
            assign sz  = (regions[g].sizeLog < `CPI_SIZE_MIN) ?
                         `CPI_SIZE_MIN : regions[g].sizeLog;
            assign sub = addr >> (sz - 5'h03); // R1
            assign hit[g] = regions[g].enable
                && ((addr >> sz) == (regions[g].base >> sz))
                && !regions[g].subOff[sub[2:0]]; // R13
        end
    endgenerate

    // Higher region number wins on overlap
    always_comb begin
        allowed = 1'b0;
        for (int i = 0; i < `CPI_NUM_REGION; i++) begin
            if (hit[i]) begin
                case (regions[i].access)
                    CPI_READ_WRITE: allowed = 1'b1;
                    CPI_READ_ONLY:  allowed = !write; // R2
                    default:        allowed = 1'b0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/cpi_regs.svh
// Operation
// R1: Eight regions, each eight equal sub-regions.
// R2: Region blocks all or permits reads only.
// R3: Unmatched or disallowed access raises fault.
// R4: Tick timer exception, clock or divided source.
// R5: Eight priority levels with hardware masking.
// R6: Vector table base relocatable by software.
// R7: Any interrupt source selectable as NMI.
// R8: Peripheral registers accept full-word writes only.
// R9: Single clock, selectable among five rates.
// R10: Three-stage overlapped fetch, decode, execute.
// R11: Separate fetch and data paths run concurrently.
// R12: 56 lines, highest priority presented, software pend.
// R13: Disabled sub-region counts as no match.
`ifndef CPI_REGS_SVH
`define CPI_REGS_SVH

`define CPI_NUM_IRQ        56
`define CPI_NUM_REGION     8
`define CPI_PRIO_BITS      3
`define CPI_TICK_BITS      24
`define CPI_ADDR_BITS      8

// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define CPI_OFS_CTRL       8'h00
`define CPI_OFS_RELOAD     8'h04
`define CPI_OFS_TICK_VAL   8'h08
`define CPI_OFS_VEC_BASE   8'h0c
`define CPI_OFS_NMI_SEL    8'h10
`define CPI_OFS_IRQ_EN0    8'h14
`define CPI_OFS_IRQ_EN1    8'h18
`define CPI_OFS_PEND0      8'h1c
`define CPI_OFS_PEND1      8'h20
`define CPI_OFS_ACTIVE     8'h24
`define CPI_OFS_INT_STAT   8'h28
`define CPI_OFS_INT_MASK   8'h2c
`define CPI_OFS_FAULT_ADR  8'h30

// ---------------------------------------------
// Fields and constants
// ---------------------------------------------
`define CPI_CTRL_PROT_EN   0
`define CPI_CTRL_TICK_EN   1
`define CPI_CTRL_TICK_DIV  2
`define CPI_CTRL_CLK_LSB   4
`define CPI_CTRL_MASK_LSB  8
`define CPI_CLK_SEL_MAX    3'h4
`define CPI_NMI_EN_BIT     7
`define CPI_ST_FAULT       0
`define CPI_ST_TICK        1
`define CPI_ST_WIDTH       2
`define CPI_RA_EN          0
`define CPI_RA_ACC_LSB     1
`define CPI_RA_SIZE_LSB    8
`define CPI_RA_SUB_LSB     16
`define CPI_SIZE_MIN       5'h08
`define CPI_VEC_ALIGN      32'hffffff80
`define CPI_VEC_FIRST_OFS  32'h00000040
`define CPI_TICK_DIV       3'h7
`define CPI_PRIO_WORDS     3'h7

`endif

//--- tb/cpi_core_model.sv
`default_nettype none
module cpi_core_model (
    input  wire logic clock,
    input  wire logic excValid,
    input  wire logic slow,
    output var logic  excAck = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] waitCnt = 2'h0;
    // Takes a vector only while one is shown, late when slow
    always @(posedge clock) begin
        waitCnt <= (excValid && !excAck) ? waitCnt + 2'h1 : 2'h0;
        excAck <= excValid && !excAck && (!slow || waitCnt == 2'h2);
    end
endmodule
`default_nettype wire

//--- tb/tb_cpu_protection_and_interrupts.sv
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb_cpu_protection_and_interrupts;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0;
    logic        ce = 1'b1;
    logic        wbWe = 1'b0, ifValid = 1'b0, dataValid = 1'b0, rw;
    logic        dataWrite = 1'b0, slow = 1'b0, wbAck, ifFault, dataFault;
    logic        memFaultExc, tickExc, excValid, excAck, nmiOut, irq;
    logic [7:0]  wbAdr = 8'h00, ra;
    logic [3:0]  wbSel = 4'h0;
    logic [31:0] wbDatIn = 32'h0, ifAddr = 32'h0, dataAddr = 32'h0;
    logic [31:0] rd, wbDatOut, excVector;
    logic [55:0] irqLine = 56'h0;
    logic [5:0]  excNum;
    logic [2:0]  sysClkSel;
    int          fails = 0, cmp_count = 0, n, l;
    cpi_core_protection dut (.clock, .reset, .clockEnable(ce), .wbCyc,
        .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatIn, .wbDatOut, .wbAck,
        .ifValid, .ifAddr, .dataValid, .dataAddr, .dataWrite, .ifFault,
        .dataFault, .memFaultExc, .tickExc, .irqLine, .excValid, .excNum,
        .excVector, .excAck, .nmiOut, .sysClkSel, .irq);
    cpi_core_model core (.clock, .excValid, .slow, .excAck);
    always #25 clock = ~clock;
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDatIn <= d;
        wbSel <= s;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatOut;
        if (n >= 20) fails++;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        `CHK(rd, e)
    endtask
    task automatic acc(input logic [31:0] ia, da, input logic w, ei, ed);
        ifValid <= 1'b1;
        ifAddr <= ia;
        dataValid <= 1'b1;
        dataAddr <= da;
        dataWrite <= w;
        @(posedge clock);
        ifValid <= 1'b0;
        ifAddr <= ~ia;
        dataValid <= 1'b0;
        dataAddr <= ~da;
        repeat (2) @(posedge clock);
        `CHK({ifFault, dataFault, memFaultExc}, {ei, ed, ei | ed})
    endtask
    task automatic waitExc();
        for (n = 0; n < 20 && excValid !== 1'b1; n++) @(posedge clock);
        if (n >= 20) fails++;
    endtask
    task automatic tickGap(input int e);
        for (n = 0; n < 99 && tickExc !== 1'b1; n++) @(posedge clock);
        @(posedge clock);
        // First gap may straddle the mode change
        for (n = 0; n < 99 && tickExc !== 1'b1; n++) @(posedge clock);
        @(posedge clock);
        for (n = 1; n < 99 && tickExc !== 1'b1; n++) @(posedge clock);
        `CHK(n, e)
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(3000 * 50);
        fails++;
        test_done();
    end
    initial begin
        void'($urandom(9997));
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rdx(8'h00, 32'h0);
        wr(8'h3c, 32'h5);
        rdx(8'h3c, 32'h0);
        wr(8'h00, 32'h41);
        wr(8'h00, 32'h51);
        `CHK(sysClkSel, 3'h4)
        // Region 0: 256 bytes read only at zero
        wr(8'h84, 32'h803);
        for (l = 0; l < 8; l++) begin
            ra = 8'($urandom);
            rw = 1'($urandom);
            acc(32'h1000, {24'h0, ra}, rw, 1'b1, rw);
        end
        wr(8'h88, 32'h100);
        wr(8'h8c, 32'h801);
        acc(32'h110, 32'h50, 1'b0, 1'b1, 1'b0);
        wr(8'h84, 32'h10803);
        acc(32'h20, 32'h10, 1'b0, 1'b0, 1'b1);
        rdx(8'h30, 32'h10);
        rdx(8'h28, 32'h1);
        wr(8'h2c, 32'h1);
        `CHK(irq, 1'b1)
        wr(8'h28, 32'h1);
        rdx(8'h28, 32'h0);
        `CHK(irq, 1'b0)
        wb(1'b1, 8'h2c, 32'h0, 4'h3);
        rdx(8'h2c, 32'h1);
        rdx(8'h28, 32'h4);
        $display("test protection done");
        wr(8'h0c, 32'h2a5);
        rdx(8'h0c, 32'h280);
        l = $urandom % 32;
        wr(8'h14, 32'h1 << l);
        wr(8'h40 + 8'(4 * (l / 8)), 32'h2 << (4 * (l % 8)));
        wr(8'h00, 32'h241);
        irqLine[l] <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK(excValid, 1'b0)
        slow <= 1'b1;
        wr(8'h00, 32'h341);
        waitExc();
        `CHK(excNum, 6'(l))
        `CHK(excVector, 32'h280 + 32'(4 * (16 + l)))
        irqLine[l] <= 1'b0;
        repeat (6) @(posedge clock);
        wr(8'h10, 32'h80 | l);
        irqLine[l] <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK({nmiOut, excValid}, 2'b10)
        $display("test interrupts done");
        wr(8'h04, 32'h3);
        wr(8'h00, 32'h43);
        tickGap(4);
        wr(8'h00, 32'h47);
        tickGap(32);
        // Frozen clock enable must hold the tick across a full period
        ce <= 1'b0;
        @(posedge clock);
        for (n = 0; n < 40 && tickExc !== 1'b1; n++) @(posedge clock);
        ce <= 1'b1;
        `CHK(n, 40)
        $display("test tick done");
        test_done();
    end
endmodule
`default_nettype wire
